//--- core/dual_channel_amp_control_regs.sv
// Control register bank of a dual-channel variable-gain amplifier,
// written and read over a 16-bit-word serial port.
// Assumes cs_n, sclk, sdi and the sleep pins are synchronous to mclk
// and that sclk is slower than half of mclk.
//
// Contract
// - Per-channel power-down bits 0 and 4, reset 0
// - Power-down bits 7:5, 3:1 read zero
// - Channel A bias register drives bias bus
// - Channel A attenuator reset by device/soft reset
// - Channel B bias ignores channel A soft reset
// - Channel B attenuator reset by B resets
// - Bias code thermometer style, nine levels
// - Bit 7 highest power; default 001xxxxx
// - Attenuator bits 7:6 read zero
// - Attenuator code binary, 0 to 39; core stores codes 40 to 63 unchecked
// - Attenuator default code 001011
// - Each code step adds one dB
// - 16-bit words, commit on 16th edge
// - Soft-reset bits clear themselves
// - Power-down never alters register contents
`timescale 1ns/1ns
`default_nettype none
module dual_channel_amp_control_regs
	import amp_ctrl_pkg::*;
(
	input wire logic mclk,
	input wire logic resetn,
	input wire logic ce,
	input wire logic cs_n,
	input wire logic sclk,
	input wire logic sdi,
	output logic sdo,
	input wire logic sleep_pin_a,
	input wire logic sleep_pin_b,
	output logic [7:0] chan_a_bias_bus,
	output logic [5:0] chan_a_atten_bus,
	output logic [7:0] chan_b_bias_bus,
	output logic [5:0] chan_b_atten_bus,
	output logic [3:0] chan_a_bias_level,
	output logic [3:0] chan_b_bias_level,
	output logic chan_a_powerdown,
	output logic chan_b_powerdown
);
	// ----------------------------------------
	// Reset release
	// ----------------------------------------
	logic [1:0] rst_sync_q;
	logic rst_n_q;
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			rst_sync_q <= 2'h0;
		end else begin
			rst_sync_q <= {rst_sync_q[0], 1'b1};
		end
	end
	assign rst_n_q = rst_sync_q[1];

	// ----------------------------------------
	// Serial shifter
	// ----------------------------------------
	logic sclk_q;
	logic [3:0] bit_cnt_q;
	logic [14:0] shift_q;
	logic [15:0] word;
	logic sclk_rise;
	logic sclk_fall;
	logic word_done;
	logic addr_done;
	logic wr_en;
	logic [6:0] wr_addr;
	logic [7:0] wr_data;
	assign sclk_rise = sclk && !sclk_q && !cs_n;
	assign sclk_fall = !sclk && sclk_q && !cs_n;
	assign word = {shift_q, sdi};
	assign word_done = sclk_rise && (bit_cnt_q == LAST_BIT);
	assign addr_done = sclk_rise && (bit_cnt_q == ADDR_LAST_BIT);
	assign wr_en = ce && word_done && !word[RD_FLAG_POS];
	assign wr_addr = word[14:8];
	assign wr_data = word[7:0];

	always_ff @(posedge mclk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			sclk_q <= 1'b0;
		end else if (ce) begin
			sclk_q <= sclk;
		end
	end

	always_ff @(posedge mclk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			bit_cnt_q <= 4'h0;
			shift_q <= 15'h0;
		end else if (ce) begin
			if (cs_n) begin
				bit_cnt_q <= 4'h0;
			end else if (sclk_rise) begin
				// Counter wraps so words stream within one select
				bit_cnt_q <= bit_cnt_q + 4'h1;
				shift_q <= word[14:0];
			end
		end
	end

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	logic chan_a_sleep_bit_q;
	logic chan_b_sleep_bit_q;
	logic soft_a_q;
	logic soft_b_q;
	logic [7:0] bias_a_q;
	logic [7:0] bias_b_q;
	logic [5:0] atten_a_q;
	logic [5:0] atten_b_q;

	always_ff @(posedge mclk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			chan_a_sleep_bit_q <= 1'b0;
			chan_b_sleep_bit_q <= 1'b0;
		end else if (wr_en && wr_addr == ADDR_PWRDN) begin
			chan_a_sleep_bit_q <= wr_data[CHAN_A_POS];
			chan_b_sleep_bit_q <= wr_data[CHAN_B_POS];
		end
	end

	always_ff @(posedge mclk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			soft_a_q <= 1'b0;
			soft_b_q <= 1'b0;
		end else if (ce) begin
			soft_a_q <= wr_en && wr_addr == ADDR_SOFT_RST && wr_data[CHAN_A_POS];
			soft_b_q <= wr_en && wr_addr == ADDR_SOFT_RST && wr_data[CHAN_B_POS];
		end
	end

	always_ff @(posedge mclk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			bias_a_q <= BIAS_RST;
			atten_a_q <= ATTEN_RST;
		end else if (ce) begin
			if (soft_a_q) begin
				bias_a_q <= BIAS_RST;
				atten_a_q <= ATTEN_RST;
			end else if (wr_en && wr_addr == ADDR_A_BIAS) begin
				bias_a_q <= wr_data;
			end else if (wr_en && wr_addr == ADDR_A_ATTEN) begin
				atten_a_q <= wr_data[ATTEN_W-1:0];
			end
		end
	end

	always_ff @(posedge mclk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			bias_b_q <= BIAS_RST;
			atten_b_q <= ATTEN_RST;
		end else if (ce) begin
			if (soft_b_q) begin
				bias_b_q <= BIAS_RST;
				atten_b_q <= ATTEN_RST;
			end else if (wr_en && wr_addr == ADDR_B_BIAS) begin
				bias_b_q <= wr_data;
			end else if (wr_en && wr_addr == ADDR_B_ATTEN) begin
				atten_b_q <= wr_data[ATTEN_W-1:0];
			end
		end
	end

	// ----------------------------------------
	// Read-back
	// ----------------------------------------
	logic [7:0] rd_data;
	logic [6:0] rd_addr;
	logic rd_act_q;
	logic [7:0] sdo_sh_q;
	assign rd_addr = word[6:0];

	always_comb begin
		rd_data = 8'h00;
		case (rd_addr)
			ADDR_PWRDN: begin
				rd_data[CHAN_A_POS] = chan_a_sleep_bit_q;
				rd_data[CHAN_B_POS] = chan_b_sleep_bit_q;
			end
			ADDR_A_BIAS: rd_data = bias_a_q;
			ADDR_A_ATTEN: rd_data = {2'h0, atten_a_q};
			ADDR_B_BIAS: rd_data = bias_b_q;
			ADDR_B_ATTEN: rd_data = {2'h0, atten_b_q};
			// Soft-reset bits self-clear, so they read as zero
			default: rd_data = 8'h00;
		endcase
	end

	// Data leaves MSB first on falling edges, ready for the next rise
	always_ff @(posedge mclk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			rd_act_q <= 1'b0;
			sdo_sh_q <= 8'h00;
			sdo <= 1'b0;
		end else if (ce) begin
			if (cs_n || word_done) begin
				rd_act_q <= 1'b0;
			end else if (addr_done && word[7]) begin
				rd_act_q <= 1'b1;
				sdo_sh_q <= rd_data;
			end else if (sclk_fall && rd_act_q) begin
				sdo <= sdo_sh_q[7];
				sdo_sh_q <= {sdo_sh_q[6:0], 1'b0};
			end
		end
	end

	// ----------------------------------------
	// Analog control outputs
	// ----------------------------------------
	// thermometer decode, highest set bit wins
	function automatic logic [3:0] bias_lvl(input logic [7:0] code);
		logic [3:0] lvl;
		lvl = 4'h0;
		for (int i = 0; i < BIAS_W; i++) begin
			if (code[i]) begin
				lvl = 4'(i + 1);
			end
		end
		return lvl;
	endfunction

	always_ff @(posedge mclk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			chan_a_bias_level <= 4'h0;
			chan_b_bias_level <= 4'h0;
			chan_a_powerdown <= 1'b0;
			chan_b_powerdown <= 1'b0;
		end else if (ce) begin
			chan_a_bias_level <= bias_lvl(bias_a_q);
			chan_b_bias_level <= bias_lvl(bias_b_q);
			chan_a_powerdown <= sleep_pin_a || chan_a_sleep_bit_q;
			chan_b_powerdown <= sleep_pin_b || chan_b_sleep_bit_q;
		end
	end
	// one dB per code step, passed straight to the attenuator
	assign chan_a_bias_bus = bias_a_q;
	assign chan_b_bias_bus = bias_b_q;
	assign chan_a_atten_bus = atten_a_q;
	assign chan_b_atten_bus = atten_b_q;

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n_q);

	property p_pd_write;
		wr_en && wr_addr == ADDR_PWRDN |=> chan_a_sleep_bit_q == $past(wr_data[0])
			&& chan_b_sleep_bit_q == $past(wr_data[4]) ##1 chan_a_powerdown
			== ($past(sleep_pin_a) || $past(chan_a_sleep_bit_q)) || !$past(ce);
	endproperty
	a_pd_write: assert property (p_pd_write) else $error("power-down bit wrong");

	property p_pd_rsv;
		ce && addr_done && word[7] && rd_addr == ADDR_PWRDN |=> (sdo_sh_q & 8'hee) == 8'h00;
	endproperty
	a_pd_rsv: assert property (p_pd_rsv) else $error("reserved bit read nonzero");

	property p_a_bias_wr;
		wr_en && wr_addr == ADDR_A_BIAS |=> chan_a_bias_bus == $past(wr_data);
	endproperty
	a_a_bias_wr: assert property (p_a_bias_wr) else $error("bias A not written");

	property p_a_soft;
		ce && soft_a_q |=> chan_a_atten_bus == ATTEN_RST && chan_a_bias_bus == BIAS_RST;
	endproperty
	a_a_soft: assert property (p_a_soft) else $error("channel A soft reset failed");

	property p_b_keep;
		ce && soft_a_q && !soft_b_q |=> $stable(chan_b_bias_bus) && $stable(chan_b_atten_bus);
	endproperty
	a_b_keep: assert property (p_b_keep) else $error("channel B hit by A reset");

	property p_b_soft;
		ce && soft_b_q |=> chan_b_atten_bus == ATTEN_RST;
	endproperty
	a_b_soft: assert property (p_b_soft) else $error("channel B soft reset failed");

	property p_lvl_zero;
		ce && chan_a_bias_bus == 8'h00 && $stable(chan_a_bias_bus) |=> chan_a_bias_level == 4'h0;
	endproperty
	a_lvl_zero: assert property (p_lvl_zero) else $error("lowest bias level wrong");

	property p_lvl_top;
		ce && chan_b_bias_bus[7] |=> chan_b_bias_level == LVL_MAX;
	endproperty
	a_lvl_top: assert property (p_lvl_top) else $error("highest bias level wrong");

	property p_atten_rsv;
		ce && addr_done && word[7] && rd_addr == ADDR_B_ATTEN |=> sdo_sh_q[7:6] == 2'h0
			&& sdo_sh_q[5:0] == chan_b_atten_bus;
	endproperty
	a_atten_rsv: assert property (p_atten_rsv) else $error("attenuator readback wrong");

	property p_defaults;
		$rose(rst_n_q) |-> chan_a_atten_bus == ATTEN_RST && chan_b_bias_bus == BIAS_RST;
	endproperty
	a_defaults: assert property (p_defaults) else $error("default value wrong");

	property p_frame;
		ce && cs_n |=> bit_cnt_q == 4'h0 ##1 !rd_act_q || !$past(ce);
	endproperty
	a_frame: assert property (p_frame) else $error("frame not restarted");

	property p_self_clr;
		ce && soft_a_q |=> !soft_a_q [*2];
	endproperty
	a_self_clr: assert property (p_self_clr) else $error("soft reset stuck");

	property p_sleep_keep;
		$rose(sleep_pin_a) && !wr_en && !soft_a_q |=> $stable(chan_a_bias_bus)
			&& $stable(chan_a_atten_bus);
	endproperty
	a_sleep_keep: assert property (p_sleep_keep) else $error("sleep altered register");

	c_write: cover property (wr_en && wr_addr == ADDR_A_ATTEN);
	c_read: cover property (addr_done && word[7] ##[1:200] word_done);
	c_soft_b: cover property (soft_b_q);
	c_stream: cover property (word_done ##[1:200] word_done);
endmodule
`default_nettype wire

//--- core/amp_ctrl_pkg.sv
// Constants for the dual-channel amplifier control register bank.
// Assumes one clock domain; serial pins are sampled on that clock.
package amp_ctrl_pkg;
	// ----------------------------------------
	// Serial word layout
	// ----------------------------------------
	localparam int WORD_BITS = 16;
	localparam logic [3:0] LAST_BIT = 4'hf;
	localparam logic [3:0] ADDR_LAST_BIT = 4'h7;
	localparam int RD_FLAG_POS = 15;
	// ----------------------------------------
	// Register addresses
	// ----------------------------------------
	localparam logic [6:0] ADDR_SOFT_RST = 7'h02;
	localparam logic [6:0] ADDR_PWRDN = 7'h03;
	localparam logic [6:0] ADDR_A_BIAS = 7'h04;
	localparam logic [6:0] ADDR_A_ATTEN = 7'h05;
	localparam logic [6:0] ADDR_B_BIAS = 7'h06;
	localparam logic [6:0] ADDR_B_ATTEN = 7'h07;
	// ----------------------------------------
	// Field positions and widths
	// ----------------------------------------
	localparam int CHAN_A_POS = 0;
	localparam int CHAN_B_POS = 4;
	localparam int ATTEN_W = 6;
	localparam int BIAS_W = 8;
	// ----------------------------------------
	// Reset values and limits
	// ----------------------------------------
	localparam logic [7:0] BIAS_RST = 8'h20;
	localparam logic [5:0] ATTEN_RST = 6'h0b;
	localparam logic [5:0] ATTEN_MAX = 6'h27;
	localparam logic [3:0] LVL_MAX = 4'h8;
endpackage

//--- tb/spi_host_model.sv
// Serial host that writes and reads the amplifier control registers.
// Assumes the device samples its pins on mclk and wants each sclk phase >= 2 mclk.
`timescale 1ns/1ns
`default_nettype none
module spi_host_model (
	input wire logic mclk,
	output logic cs_n,
	output logic sclk,
	output logic sdi,
	input wire logic sdo
);
	localparam int HALF = 4;
	initial begin
		cs_n = 1'b1;
		sclk = 1'b0;
		sdi = 1'b0;
	end
	// ----------------------------------------
	// Word transfer
	// ----------------------------------------
	// whole 16-bit words, read flag first; callers keep codes in range
	task automatic xfer(input logic [15:0] word, input logic last, output logic [7:0] rd);
		rd = 8'h00;
		@(posedge mclk);
		#1 cs_n = 1'b0;
		for (int i = 15; i >= 0; i--) begin
			sdi = word[i];
			repeat (HALF) @(posedge mclk);
			#1 sclk = 1'b1;
			if (i < 8) begin
				rd = {rd[6:0], sdo};
			end
			repeat (HALF) @(posedge mclk);
			#1 sclk = 1'b0;
		end
		if (last) begin
			repeat (HALF) @(posedge mclk);
			#1 cs_n = 1'b1;
			// Released data line must not keep showing the last bit
			sdi = ~sdi;
		end
	endtask
endmodule
`default_nettype wire

//--- tb/dual_channel_amp_control_regs_tb.sv
// Self-checking bench for the amplifier control register bank.
// Assumes the serial host model drives the port; bench drives ce and sleep pins.
`timescale 1ns/1ns
`default_nettype none
module dual_channel_amp_control_regs_tb;
	import amp_ctrl_pkg::*;
	logic mclk, resetn, ce, cs_n, sclk, sdi, sdo, sleep_pin_a, sleep_pin_b, a_pd, b_pd;
	logic [7:0] a_bias, b_bias;
	logic [5:0] a_att, b_att;
	logic [3:0] a_lvl, b_lvl;
	int n_errors = 0;
	int check_count = 0;
	dual_channel_amp_control_regs i_dual_channel_amp_control_regs (.mclk(mclk),
		.resetn(resetn), .ce(ce), .cs_n(cs_n), .sclk(sclk), .sdi(sdi), .sdo(sdo),
		.sleep_pin_a(sleep_pin_a), .sleep_pin_b(sleep_pin_b), .chan_a_bias_bus(a_bias),
		.chan_a_atten_bus(a_att), .chan_b_bias_bus(b_bias), .chan_b_atten_bus(b_att),
		.chan_a_bias_level(a_lvl), .chan_b_bias_level(b_lvl),
		.chan_a_powerdown(a_pd), .chan_b_powerdown(b_pd));
	spi_host_model i_spi_host_model (.mclk(mclk), .cs_n(cs_n), .sclk(sclk), .sdi(sdi),
		.sdo(sdo));
	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end
	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		check_count++;
		if (got !== exp) begin
			n_errors++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic summarize();
		if (n_errors == 0 && check_count > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		logic [7:0] r;
		i_spi_host_model.xfer({1'b0, a, d}, 1'b1, r);
	endtask
	task automatic rd_chk(input logic [6:0] a, input logic [7:0] e);
		logic [7:0] r;
		i_spi_host_model.xfer({1'b1, a, 8'h00}, 1'b1, r);
		chk(r, e);
	endtask
	task automatic do_reset();
		@(posedge mclk);
		#1 resetn = 1'b0;
		repeat (10) @(posedge mclk);
		#1 resetn = 1'b1;
		repeat (5) @(posedge mclk);
	endtask
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_defaults();
		chk(a_bias, BIAS_RST);
		chk({2'h0, a_att}, {2'h0, ATTEN_RST});
		chk(b_bias, BIAS_RST);
		chk({2'h0, b_att}, {2'h0, ATTEN_RST});
		chk({6'h00, b_pd, a_pd}, 8'h00);
		chk({4'h0, a_lvl}, 8'h06);
		rd_chk(ADDR_PWRDN, 8'h00);
		rd_chk(ADDR_A_ATTEN, {2'h0, ATTEN_RST});
		rd_chk(ADDR_B_BIAS, BIAS_RST);
		rd_chk(7'h08, 8'h00);
	endtask
	task automatic t_bias();
		logic [7:0] fill, single;
		for (int k = 0; k <= 8; k++) begin
			fill = 8'(9'h1ff >> (9 - k));
			single = (k == 0) ? 8'h00 : 8'(9'h001 << (k - 1));
			wr(ADDR_B_BIAS, fill);
			wr(ADDR_A_BIAS, single);
			chk(b_bias, fill);
			chk({4'h0, b_lvl}, 8'(k));
			chk(a_bias, single);
			chk({4'h0, a_lvl}, 8'(k));
		end
	endtask
	task automatic t_atten();
		wr(ADDR_A_ATTEN, 8'he7);
		chk({2'h0, a_att}, {2'h0, ATTEN_MAX});
		rd_chk(ADDR_A_ATTEN, 8'h27);
		wr(ADDR_B_ATTEN, 8'hc0);
		chk({2'h0, b_att}, 8'h00);
		rd_chk(ADDR_B_ATTEN, 8'h00);
	endtask
	task automatic t_pwrdn();
		wr(ADDR_PWRDN, 8'hff);
		chk({6'h00, b_pd, a_pd}, 8'h03);
		rd_chk(ADDR_PWRDN, 8'h11);
		chk({2'h0, a_att}, 8'h27);
		chk(b_bias, 8'hff);
		wr(ADDR_PWRDN, 8'h00);
		@(posedge mclk);
		#1 sleep_pin_a = 1'b1;
		repeat (3) @(posedge mclk);
		#1 chk({6'h00, b_pd, a_pd}, 8'h01);
		chk(a_bias, 8'h80);
		sleep_pin_a = 1'b0;
		sleep_pin_b = 1'b1;
		repeat (3) @(posedge mclk);
		#1 chk({6'h00, b_pd, a_pd}, 8'h02);
		chk(b_bias, 8'hff);
		// Pin sleep must leave the register bits clear
		rd_chk(ADDR_PWRDN, 8'h00);
		sleep_pin_b = 1'b0;
	endtask
	task automatic t_softrst();
		wr(ADDR_B_ATTEN, 8'h26);
		wr(ADDR_SOFT_RST, 8'h01);
		chk(a_bias, BIAS_RST);
		chk({2'h0, a_att}, {2'h0, ATTEN_RST});
		chk(b_bias, 8'hff);
		chk({2'h0, b_att}, 8'h26);
		rd_chk(ADDR_SOFT_RST, 8'h00);
		wr(ADDR_SOFT_RST, 8'h10);
		chk(b_bias, BIAS_RST);
		chk({2'h0, b_att}, {2'h0, ATTEN_RST});
	endtask
	task automatic t_stream();
		logic [7:0] r;
		// Two words under one select, then a read word that carries data bits
		i_spi_host_model.xfer({1'b0, ADDR_A_BIAS, 8'h40}, 1'b0, r);
		i_spi_host_model.xfer({1'b0, ADDR_B_BIAS, 8'h08}, 1'b0, r);
		i_spi_host_model.xfer({1'b1, ADDR_A_BIAS, 8'hff}, 1'b1, r);
		chk(r, 8'h40);
		chk(a_bias, 8'h40);
		chk(b_bias, 8'h08);
	endtask
	task automatic t_ce();
		@(posedge mclk);
		#1 ce = 1'b0;
		wr(ADDR_A_BIAS, 8'h01);
		ce = 1'b1;
		chk(a_bias, 8'h40);
		// Port must work again once enabled; the reset that follows must clear this
		wr(ADDR_PWRDN, 8'h11);
		chk({6'h00, b_pd, a_pd}, 8'h03);
	endtask
	initial begin
		resetn = 1'b0;
		ce = 1'b1;
		sleep_pin_a = 1'b0;
		sleep_pin_b = 1'b0;
		do_reset();
		t_defaults();
		t_bias();
		t_atten();
		t_pwrdn();
		t_softrst();
		t_stream();
		t_ce();
		do_reset();
		t_defaults();
		summarize();
	end
	// Full run takes about 5750 cycles; a stuck port stops here
	initial begin
		repeat (20000) @(posedge mclk);
		n_errors++;
		summarize();
	end
endmodule
`default_nettype wire
